// ==== inc/ucp_baud_if.sv ====
// divider setting and bit tick between an engine and its baud generator
`timescale 1ns/1ns
`default_nettype none
interface ucp_baud_if;
    logic [6:0] div;
    logic       restart;
    logic       half;
    logic       tick;
    modport gen  (input div, input restart, input half, output tick);
    modport user (output div, output restart, output half, input tick);
endinterface
`default_nettype wire

// ==== inc/ucp_cfg.svh ====
// register offsets, field positions and reset values of the channel pair
`ifndef UCP_CFG_SVH
`define UCP_CFG_SVH
`define UCP_OFF_RX_DIV    8'h00
`define UCP_OFF_TX_DIV    8'h04
`define UCP_OFF_CHAN_CFG  8'h08
`define UCP_OFF_LEVEL     8'h0C
`define UCP_OFF_OE        8'h10
`define UCP_OFF_LATCH     8'h14
`define UCP_OFF_DIR       8'h18
`define UCP_OFF_FLAGS     8'h1C
`define UCP_OFF_MASK      8'h20
`define UCP_OFF_START     8'h24
`define UCP_OFF_STATUS    8'h28
`define UCP_OFF_TX_DATA   8'h2C
`define UCP_OFF_RX_DATA   8'h30
`define UCP_DIV_LSB       9
`define UCP_CFG_TXE       15
`define UCP_CFG_RXE       14
`define UCP_CFG_STS       12
`define UCP_CFG_PAR_LSB   8
`define UCP_CFG_STOP_LSB  4
`define UCP_CFG_LEN_LSB   0
`define UCP_PIN_TX        4
`define UCP_PIN_RX        5
`define UCP_FLAG_ERR      5
`define UCP_FLAG_REND     2
`define UCP_FLAG_TEND     1
`define UCP_RST_DIV       7'h00
`define UCP_RST_LEVEL     1'b1
`define UCP_RST_DIR       8'hFF
`define UCP_RST_LATCH     8'h00
`define UCP_RST_MASK      8'hFF
`endif

// ==== inc/ucp_pkg.sv ====
// types of the channel pair
package ucp_pkg;
    typedef enum logic [1:0] {UCP_TX_IDLE = 2'b01, UCP_TX_BUSY = 2'b10} ucp_tx_st_t;
    typedef enum logic [1:0] {UCP_RX_IDLE = 2'b01, UCP_RX_BUSY = 2'b10} ucp_rx_st_t;
    typedef struct packed {
        logic [7:0] cnt;
    } ucp_baud_t;
    typedef struct packed {
        logic [6:0]  rx_div;
        logic [6:0]  tx_div;
        logic        txe;
        logic        rxe;
        logic        sts;
        logic [1:0]  par;
        logic [1:0]  stop;
        logic [1:0]  len;
        logic        level;
        logic        soe;
        logic [7:0]  latch;
        logic [7:0]  dir;
        logic [7:0]  mask;
        logic        f_err;
        logic        f_rend;
        logic        f_tend;
        logic [1:0]  op;
        logic        rx_arm;
        ucp_tx_st_t  tx_st;
        logic [12:0] tx_sh;
        logic [3:0]  tx_cnt;
        ucp_rx_st_t  rx_st;
        logic [12:0] rx_sh;
        logic [3:0]  rx_cnt;
        logic [8:0]  rx_data;
        logic        rx_full;
        logic        rx_prev;
        logic [7:0]  sync1;
        logic [7:0]  sync2;
        logic        dp_wr;
        logic        rd_pend;
        logic [7:0]  dp_addr;
        logic [31:0] hrdata;
        logic        hready;
        logic [7:0]  pin_out;
        logic [7:0]  pin_oe;
        logic [2:0]  irq;
    } ucp_state_t;
endpackage

// ==== rtl/ucp_baud_gen.sv ====
// bit-rate tick generator, one tick per 2*(div+1) clocks
`timescale 1ns/1ns
`default_nettype none
module ucp_baud_gen (
    input  wire logic hclk,
    input  wire logic hresetn,
    ucp_baud_if.gen   bi
);
    ucp_pkg::ucp_baud_t s_q;
    ucp_pkg::ucp_baud_t s_d;
    logic [8:0]         gap;
    logic               seen;

    always_comb begin
        s_d = s_q;
        if (bi.restart) begin
            s_d.cnt = bi.half ? {1'b0, bi.div} : {bi.div, 1'b1};
        end else if (s_q.cnt == 8'h00) begin
            s_d.cnt = {bi.div, 1'b1};
        end else begin
            s_d.cnt = s_q.cnt - 8'h01;
        end
    end

    assign bi.tick = !bi.restart && (s_q.cnt == 8'h00);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // spacing watch for the period check
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap  <= 9'h000;
            seen <= 1'b0;
        end else begin
            gap  <= (bi.tick || bi.restart) ? 9'h000 : gap + 9'h001;
            seen <= bi.restart ? 1'b0 : (bi.tick | seen);
        end
    end

    AST_BAUD_PERIOD: assert property (@(posedge hclk) disable iff (!hresetn)
        bi.tick && seen && $stable(bi.div) |-> gap == {1'b0, bi.div, 1'b1})
        else $error("tick spacing differs from twice divider plus one");
endmodule // ucp_baud_gen
`default_nettype wire

// ==== rtl/ucp_channel_pair.sv ====
// asynchronous serial transmit/receive channel pair with AHB-Lite registers
`timescale 1ns/1ns
`default_nettype none
`include "ucp_cfg.svh"
module ucp_channel_pair (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    output logic             irq_rx_error,
    output logic             irq_rx_end,
    output logic             irq_tx_end
);
    ucp_pkg::ucp_state_t s_q;
    ucp_pkg::ucp_state_t s_d;
    logic [31:0]         rd;
    logic                tx_done;
    logic                rx_done;
    logic                rx_bad;
    logic                rx_bit;
    logic [16:0]         fr;
    logic [12:0]         smp;
    logic [12:0]         vm;
    logic [8:0]          rdat;
    logic [3:0]          rx_len;
    logic                hresp_q;

    ucp_baud_if tx_b ();
    ucp_baud_if rx_b ();

    assign tx_b.div     = s_q.tx_div;
    assign tx_b.restart = (s_q.tx_st == ucp_pkg::UCP_TX_IDLE);
    assign tx_b.half    = 1'b0;
    assign rx_b.div     = s_q.rx_div;
    assign rx_b.restart = (s_q.rx_st == ucp_pkg::UCP_RX_IDLE);
    assign rx_b.half    = 1'b1;

    ucp_baud_gen u_tx_baud (
        .hclk    (hclk),
        .hresetn (hresetn),
        .bi      (tx_b)
    );

    ucp_baud_gen u_rx_baud (
        .hclk    (hclk),
        .hresetn (hresetn),
        .bi      (rx_b)
    );

    // number of data bits for a length code
    function automatic logic [3:0] ucp_nd(input logic [1:0] len);
        return (len == 2'b01) ? 4'h9 : ((len == 2'b10) ? 4'h7 : 4'h8);
    endfunction

    // frame image, lsb first, padded with idle ones; bit count on top
    function automatic logic [16:0] ucp_frame(input logic [8:0] d, input logic [1:0] len,
                                              input logic [1:0] par, input logic [1:0] stop);
        logic [12:0] b;
        logic [3:0]  n;
        logic [3:0]  pos;
        logic        p;
        n    = ucp_nd(len);
        b    = 13'h1FFF;
        b[0] = 1'b0;
        p    = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) begin
                b[i+1] = d[i];
                p      = p ^ d[i];
            end
        end
        pos = n + 4'h1;
        if (par != 2'b00) begin
            b[pos] = (par == 2'b01) ? 1'b0 : ((par == 2'b10) ? p : ~p);
            pos    = pos + 4'h1;
        end
        // prohibited stop code 11 sends one stop bit
        pos = pos + ((stop == 2'b10) ? 4'h2 : ((stop == 2'b00) ? 4'h0 : 4'h1));
        return {pos, b};
    endfunction

    always_comb begin
        s_d     = s_q;
        rd      = 32'h0000_0000;
        tx_done = 1'b0;
        rx_done = 1'b0;
        rx_bad  = 1'b0;
        rx_bit  = s_q.sync2[`UCP_PIN_RX];
        smp     = s_q.rx_sh;
        vm      = 13'h0000;
        rdat    = 9'h000;
        fr      = ucp_frame(9'h000, s_q.len, s_q.par, s_q.stop);
        rx_len  = fr[16:13];

        s_d.sync1   = pin_in;
        s_d.sync2   = s_q.sync1;
        s_d.rx_prev = s_q.sync2[`UCP_PIN_RX];

        // address phase; reads take one wait state
        s_d.dp_wr   = 1'b0;
        s_d.rd_pend = 1'b0;
        s_d.hready  = 1'b1;
        if (hsel && hready && htrans[1]) begin
            s_d.dp_addr = haddr[7:0];
            s_d.dp_wr   = hwrite;
            s_d.rd_pend = !hwrite;
            s_d.hready  = hwrite;
        end

        case (s_q.dp_addr)
            `UCP_OFF_RX_DIV:   rd[15:`UCP_DIV_LSB] = s_q.rx_div;
            `UCP_OFF_TX_DIV:   rd[15:`UCP_DIV_LSB] = s_q.tx_div;
            `UCP_OFF_CHAN_CFG: begin
                rd[`UCP_CFG_TXE] = s_q.txe;
                rd[`UCP_CFG_RXE] = s_q.rxe;
                rd[`UCP_CFG_STS] = s_q.sts;
                rd[`UCP_CFG_PAR_LSB+:2]  = s_q.par;
                rd[`UCP_CFG_STOP_LSB+:2] = s_q.stop;
                rd[`UCP_CFG_LEN_LSB+:2]  = s_q.len;
            end
            `UCP_OFF_LEVEL:    rd[0] = s_q.level;
            `UCP_OFF_OE:       rd[0] = s_q.soe;
            `UCP_OFF_LATCH:    rd[7:0] = s_q.latch;
            `UCP_OFF_DIR:      rd[7:0] = s_q.dir;
            `UCP_OFF_FLAGS: begin
                rd[`UCP_FLAG_ERR]  = s_q.f_err;
                rd[`UCP_FLAG_REND] = s_q.f_rend;
                rd[`UCP_FLAG_TEND] = s_q.f_tend;
            end
            `UCP_OFF_MASK:     rd[7:0] = s_q.mask;
            `UCP_OFF_STATUS: begin
                rd[1:0] = s_q.op;
                rd[2]   = (s_q.tx_st == ucp_pkg::UCP_TX_BUSY);
                rd[3]   = (s_q.rx_st == ucp_pkg::UCP_RX_BUSY);
                rd[4]   = s_q.rx_full;
            end
            `UCP_OFF_RX_DATA:  rd[8:0] = s_q.rx_data;
            default:           rd = 32'h0000_0000;
        endcase
        if (s_q.rd_pend) begin
            s_d.hrdata = rd;
            if (s_q.dp_addr == `UCP_OFF_RX_DATA) begin
                s_d.rx_full = 1'b0;
            end
        end

        // write data phase
        if (s_q.dp_wr) begin
            case (s_q.dp_addr)
                `UCP_OFF_RX_DIV:   s_d.rx_div = hwdata[15:`UCP_DIV_LSB];
                `UCP_OFF_TX_DIV:   s_d.tx_div = hwdata[15:`UCP_DIV_LSB];
                `UCP_OFF_CHAN_CFG: begin
                    s_d.txe  = hwdata[`UCP_CFG_TXE];
                    s_d.rxe  = hwdata[`UCP_CFG_RXE];
                    s_d.sts  = hwdata[`UCP_CFG_STS];
                    s_d.par  = hwdata[`UCP_CFG_PAR_LSB+:2];
                    s_d.stop = hwdata[`UCP_CFG_STOP_LSB+:2];
                    s_d.len  = hwdata[`UCP_CFG_LEN_LSB+:2];
                end
                `UCP_OFF_LEVEL:    s_d.level = hwdata[0];
                `UCP_OFF_OE:       s_d.soe = hwdata[0];
                `UCP_OFF_LATCH:    s_d.latch = hwdata[7:0];
                `UCP_OFF_DIR:      s_d.dir = hwdata[7:0];
                `UCP_OFF_FLAGS: begin
                    s_d.f_err  = hwdata[`UCP_FLAG_ERR];
                    s_d.f_rend = hwdata[`UCP_FLAG_REND];
                    s_d.f_tend = hwdata[`UCP_FLAG_TEND];
                end
                `UCP_OFF_MASK:     s_d.mask = hwdata[7:0];
                `UCP_OFF_START: begin
                    s_d.op = s_q.op | hwdata[1:0];
                    if (hwdata[1] && !s_q.sts) begin
                        s_d.rx_arm = 1'b1;
                    end
                end
                `UCP_OFF_TX_DATA: begin
                    if (s_q.op[0] && s_q.txe && (s_q.tx_st == ucp_pkg::UCP_TX_IDLE)) begin
                        {s_d.tx_cnt, s_d.tx_sh} = ucp_frame(hwdata[8:0], s_q.len,
                                                            s_q.par, s_q.stop);
                        s_d.tx_st = ucp_pkg::UCP_TX_BUSY;
                    end
                end
                default: ;
            endcase
        end

        // transmitter
        unique case (s_q.tx_st)
            ucp_pkg::UCP_TX_IDLE: ;
            ucp_pkg::UCP_TX_BUSY: begin
                if (tx_b.tick) begin
                    s_d.tx_sh  = {1'b1, s_q.tx_sh[12:1]};
                    s_d.tx_cnt = s_q.tx_cnt - 4'h1;
                    if (s_q.tx_cnt == 4'h1) begin
                        s_d.tx_st = ucp_pkg::UCP_TX_IDLE;
                        tx_done   = 1'b1;
                    end
                end
            end
        endcase

        // receiver
        unique case (s_q.rx_st)
            ucp_pkg::UCP_RX_IDLE: begin
                if (s_q.op[1] && s_q.rxe &&
                    ((s_q.sts && s_q.rx_prev && !rx_bit) || s_q.rx_arm)) begin
                    s_d.rx_st  = ucp_pkg::UCP_RX_BUSY;
                    s_d.rx_cnt = 4'h0;
                    s_d.rx_arm = 1'b0;
                end
            end
            ucp_pkg::UCP_RX_BUSY: begin
                if (rx_b.tick) begin
                    smp[s_q.rx_cnt] = rx_bit;
                    s_d.rx_sh  = smp;
                    s_d.rx_cnt = s_q.rx_cnt + 4'h1;
                    if (s_q.rx_cnt == rx_len - 4'h1) begin
                        for (int i = 0; i < 9; i++) begin
                            if (i < int'(ucp_nd(s_q.len))) begin
                                rdat[i] = smp[i+1];
                            end
                        end
                        fr = ucp_frame(rdat, s_q.len, s_q.par, s_q.stop);
                        vm = 13'h1FFF >> (4'hD - rx_len);
                        if (s_q.par == 2'b01) begin
                            vm[ucp_nd(s_q.len) + 4'h1] = 1'b0;
                        end
                        // start and stop positions must match, and parity too except for parity code 01
                        rx_bad      = (|((fr[12:0] ^ smp) & vm)) || s_q.rx_full;
                        rx_done     = 1'b1;
                        s_d.rx_data = rdat;
                        s_d.rx_full = 1'b1;
                        s_d.rx_st   = ucp_pkg::UCP_RX_IDLE;
                    end
                end
            end
        endcase

        // set wins over a software clear in the same cycle
        s_d.f_tend = s_d.f_tend | tx_done;
        s_d.f_rend = s_d.f_rend | rx_done;
        s_d.f_err  = s_d.f_err | rx_bad;

        s_d.irq = {s_q.f_err & ~s_q.mask[`UCP_FLAG_ERR],
                   s_q.f_rend & ~s_q.mask[`UCP_FLAG_REND],
                   s_q.f_tend & ~s_q.mask[`UCP_FLAG_TEND]};

        s_d.pin_oe  = ~s_q.dir;
        s_d.pin_out = s_q.latch;
        if (s_q.soe) begin
            s_d.pin_out[`UCP_PIN_TX] = (s_q.tx_st == ucp_pkg::UCP_TX_BUSY) ?
                                       s_q.tx_sh[0] : s_q.level;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q        <= '0;
            s_q.rx_div <= `UCP_RST_DIV;
            s_q.tx_div <= `UCP_RST_DIV;
            s_q.level  <= `UCP_RST_LEVEL;
            s_q.latch  <= `UCP_RST_LATCH;
            s_q.dir    <= `UCP_RST_DIR;
            s_q.mask   <= `UCP_RST_MASK;
            s_q.tx_st  <= ucp_pkg::UCP_TX_IDLE;
            s_q.rx_st  <= ucp_pkg::UCP_RX_IDLE;
            s_q.sync1  <= 8'hFF;
            s_q.sync2  <= 8'hFF;
            s_q.rx_prev <= 1'b1;
            s_q.hready <= 1'b1;
            s_q.pin_out <= `UCP_RST_LATCH;
            hresp_q    <= 1'b0;
        end else begin
            s_q        <= s_d;
            hresp_q    <= 1'b0;
        end
    end

    assign hrdata       = s_q.hrdata;
    assign hreadyout    = s_q.hready;
    assign hresp        = hresp_q;
    assign pin_out      = s_q.pin_out;
    assign pin_oe       = s_q.pin_oe;
    assign irq_rx_error = s_q.irq[2];
    assign irq_rx_end   = s_q.irq[1];
    assign irq_tx_end   = s_q.irq[0];

    default clocking ucp_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_start_wr(int b);
        s_q.dp_wr && (s_q.dp_addr == `UCP_OFF_START) && hwdata[b];
    endsequence

    AST_START_SETS_OP: assert property (s_start_wr(0) |=> s_q.op[0] [*2])
        else $error("start bit write did not set operating status");
    AST_START_ZERO: assert property (s_q.dp_wr && (s_q.dp_addr == `UCP_OFF_START)
        && !hwdata[1] && !s_q.op[1] |=> !s_q.op[1])
        else $error("writing zero to start bit changed status");
    AST_TX_LEVEL: assert property ((s_q.tx_st == ucp_pkg::UCP_TX_IDLE) && s_q.soe
        |=> pin_out[`UCP_PIN_TX] == $past(s_q.level))
        else $error("idle transmit pin differs from output level");
    AST_TX_STOPPED: assert property (!s_q.soe
        |=> pin_out[`UCP_PIN_TX] == $past(s_q.latch[`UCP_PIN_TX]))
        else $error("serial output not stopped while disabled");
    AST_PIN_LATCH: assert property (1'b1 |=>
        (pin_out & 8'hEF) == ($past(s_q.latch) & 8'hEF))
        else $error("pin does not follow its latch bit");
    AST_PIN_DIR: assert property (1'b1 |=> pin_oe == ~$past(s_q.dir))
        else $error("pin buffer enable does not follow direction");
    AST_TEND_FLAG: assert property (tx_done |=> s_q.f_tend ##1 irq_tx_end == !s_q.mask[1])
        else $error("transmit end flag or interrupt missing");
    AST_REND_FLAG: assert property (rx_done |=> s_q.f_rend && s_q.rx_full)
        else $error("receive end flag missing after frame");
    AST_ERR_MASK: assert property (1'b1 |=>
        irq_rx_error == ($past(s_q.f_err) && !$past(s_q.mask[`UCP_FLAG_ERR])))
        else $error("error interrupt does not respect its mask");
    AST_ERR_FLAG: assert property (rx_bad |=> s_q.f_err)
        else $error("receive error flag missing");
endmodule // ucp_channel_pair
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench of the serial channel pair
`timescale 1ns/1ns
`default_nettype none
`include "ucp_cfg.svh"
module tb_top;
    logic        hclk, hresetn, hwrite, hreadyout, hresp, rx_line, ok;
    logic        irq_rx_error, irq_rx_end, irq_tx_end;
    logic [31:0] haddr, hwdata, hrdata, rd, cfg;
    logic [1:0]  htrans;
    logic [7:0]  pin_misc, pin_out, pin_oe, f, m;
    logic [8:0]  got, dat;
    int          err_total, n_tests, nb, per;
    logic [7:0]  ra [9] = '{`UCP_OFF_LEVEL, `UCP_OFF_OE, `UCP_OFF_LATCH, `UCP_OFF_DIR,
                           `UCP_OFF_MASK, `UCP_OFF_FLAGS, `UCP_OFF_STATUS, `UCP_OFF_RX_DIV, 8'h3C};
    logic [31:0] rv [9] = '{32'h1, 32'h0, 32'h0, 32'hFF, 32'hFF, 32'h0, 32'h0, 32'h0, 32'h0};
    ucp_channel_pair DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pin_in({pin_misc[7:6], rx_line, pin_misc[4:0]}), .pin_out(pin_out), .pin_oe(pin_oe),
        .irq_rx_error(irq_rx_error), .irq_rx_end(irq_rx_end), .irq_tx_end(irq_tx_end)
    );
    // an undriven transmit pin floats high through its pull-up
    ucp_peer_model peer (.hclk(hclk), .line_in(pin_oe[4] ? pin_out[4] : 1'b1),
                         .line_out(rx_line));
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    function automatic int len_bits(input logic [1:0] c);
        return (c == 2'b01) ? 9 : (c == 2'b10) ? 7 : 8;
    endfunction
    initial begin
        repeat (60000) @(posedge hclk);
        err_total++;
        $display("BAD watchdog expired");
        complete_run();
    end
    initial begin
        hresetn = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        pin_misc = 8'hFF;
        err_total = 0;
        n_tests = 0;
        void'($urandom(37));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("pin_oe", {24'h0, pin_oe}, 32'h0);
        foreach (ra[i]) begin
            bus(1'b0, ra[i], 32'h0, rd);
            chk("reset value", rd, rv[i]);
        end
        for (int i = 0; i < 4; i++) begin
            f = 8'($urandom);
            m = 8'($urandom);
            pin_misc <= 8'($urandom);
            wr(`UCP_OFF_DIR, {24'h0, f});
            wr(`UCP_OFF_LATCH, {24'h0, m});
            repeat (2) @(posedge hclk);
            chk("pin_oe", {24'h0, pin_oe}, {24'h0, ~f});
            chk("pin_out", {24'h0, pin_out & ~f}, {24'h0, m & ~f});
        end
        for (int i = 0; i < 6; i++) begin
            f = (i == 0) ? 8'h26 : 8'($urandom) & 8'h26;
            m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            wr(`UCP_OFF_FLAGS, {24'h0, f});
            wr(`UCP_OFF_MASK, {24'h0, m});
            repeat (2) @(posedge hclk);
            chk("irq", {29'h0, irq_rx_error, irq_rx_end, irq_tx_end},
                {29'h0, f[5] & ~m[5], f[2] & ~m[2], f[1] & ~m[1]});
            bus(1'b0, `UCP_OFF_FLAGS, 32'h0, rd);
            chk("flags", rd & 32'h26, {24'h0, f});
        end
        wr(`UCP_OFF_FLAGS, 32'h0);
        wr(`UCP_OFF_MASK, 32'hD9);
        for (int i = 0; i < 2; i++) begin
            wr(`UCP_OFF_START, 32'(i));
            bus(1'b0, `UCP_OFF_STATUS, 32'h0, rd);
            chk("status", rd & 32'h3, 32'(i));
        end
        wr(`UCP_OFF_DIR, 32'hEF);
        wr(`UCP_OFF_LATCH, 32'h00);
        for (int i = 0; i < 4; i++) begin
            wr(`UCP_OFF_LEVEL, 32'(i & 1));
            wr(`UCP_OFF_OE, 32'(i >> 1));
            repeat (2) @(posedge hclk);
            chk("tx pin", {31'h0, pin_out[4]}, (i > 1) ? 32'(i & 1) : 32'h0);
        end
        wr(`UCP_OFF_LATCH, 32'h10);
        for (int i = 0; i < 6; i++) begin
            per = 2 * (1 + ($urandom % 4));
            cfg = 32'h8000 | 32'((i % 4) << 8) | 32'((i % 3) << 4) | 32'(1 + i % 3);
            nb = len_bits(cfg[1:0]);
            dat = 9'($urandom) & 9'((1 << nb) - 1);
            wr(`UCP_OFF_TX_DIV, 32'((per / 2 - 1) << 9));
            wr(`UCP_OFF_CHAN_CFG, cfg);
            fork
                peer.recv(nb, cfg[9:8], int'(cfg[5:4]), per, got, ok);
                wr(`UCP_OFF_TX_DATA, {23'h0, dat});
            join
            chk("tx data", {23'h0, got}, {23'h0, dat});
            chk("tx frame", {31'h0, ok}, 32'h1);
            for (int k = 0; k < 50 && irq_tx_end !== 1'b1; k++) @(posedge hclk);
            chk("tx end", {31'h0, irq_tx_end}, 32'h1);
            wr(`UCP_OFF_FLAGS, 32'h0);
        end
        wr(`UCP_OFF_RX_DIV, 32'h9A00);
        wr(`UCP_OFF_CHAN_CFG, 32'h5013);
        repeat (4) @(posedge hclk);
        wr(`UCP_OFF_START, 32'h3);
        bus(1'b0, `UCP_OFF_STATUS, 32'h0, rd);
        chk("status", rd & 32'h3, 32'h3);
        for (int i = 0; i < 4; i++) begin
            cfg = 32'h5013 | 32'(i << 8);
            wr(`UCP_OFF_CHAN_CFG, cfg);
            dat = 9'($urandom % 256);
            peer.send(dat, 8, cfg[9:8], 1, i == 3, 156);
            for (int k = 0; k < 300 && irq_rx_end !== 1'b1; k++) @(posedge hclk);
            chk("rx end", {31'h0, irq_rx_end}, 32'h1);
            chk("rx error", {31'h0, irq_rx_error}, 32'(i == 3));
            bus(1'b0, `UCP_OFF_RX_DATA, 32'h0, rd);
            if (i != 3) chk("rx data", rd & 32'h1FF, {23'h0, dat});
            wr(`UCP_OFF_FLAGS, 32'h0);
        end
        // software trigger only: a line edge alone must not start a frame
        wr(`UCP_OFF_CHAN_CFG, 32'h4013);
        peer.send(9'h0A5, 8, 2'b00, 1, 1'b0, 156);
        chk("edge ignored", {31'h0, irq_rx_end}, 32'h0);
        // armed frames; the second lands on unread data and overruns
        for (int i = 0; i < 2; i++) begin
            dat = 9'($urandom % 256);
            repeat (8) @(posedge hclk);
            fork
                peer.send(dat, 8, 2'b00, 1, 1'b0, 156);
                wr(`UCP_OFF_START, 32'h2);
            join
            for (int k = 0; k < 300 && irq_rx_end !== 1'b1; k++) @(posedge hclk);
            chk("armed rx end", {31'h0, irq_rx_end}, 32'h1);
            chk("overrun", {31'h0, irq_rx_error}, 32'(i));
            wr(`UCP_OFF_FLAGS, 32'h0);
        end
        bus(1'b0, `UCP_OFF_RX_DATA, 32'h0, rd);
        chk("armed rx data", rd & 32'h1FF, {23'h0, dat});
        chk("hresp", {31'h0, hresp}, 32'h0);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire

// ==== verification/ucp_peer_model.sv ====
// remote serial peer that sends and receives asynchronous frames
`timescale 1ns/1ns
`default_nettype none
module ucp_peer_model (
    input  wire logic hclk,
    input  wire logic line_in,
    output logic      line_out
);
    initial line_out = 1'b1;
    function automatic logic par_bit(input logic [8:0] d, input int nb, input logic [1:0] p);
        logic x;
        x = ^(d & 9'((1 << nb) - 1));
        return (p == 2'b10) ? x : (p == 2'b11) ? ~x : 1'b0;
    endfunction
    // frame lsb first; positions past data and parity stay high as stop bits
    task automatic send(input logic [8:0] d, input int nb, input logic [1:0] p, input int ns,
                        input logic bad, input int per);
        logic [12:0] fb;
        int          n;
        fb    = 13'h1FFF;
        fb[0] = 1'b0;
        for (int i = 0; i < nb; i++) begin
            fb[i+1] = d[i];
        end
        n = nb + 1;
        if (p != 2'b00) begin
            fb[n] = par_bit(d, nb, p) ^ bad;
            n++;
        end
        for (int i = 0; i < n + ns; i++) begin
            line_out <= fb[i];
            repeat (per) @(posedge hclk);
        end
        line_out <= 1'b1;
    endtask
    task automatic recv(input int nb, input logic [1:0] p, input int ns, input int per,
                        output logic [8:0] d, output logic ok);
        d = 9'h000;
        @(negedge line_in);
        repeat (per / 2) @(posedge hclk);
        ok = (line_in === 1'b0);
        for (int i = 0; i < nb; i++) begin
            repeat (per) @(posedge hclk);
            d[i] = line_in;
        end
        if (p != 2'b00) begin
            repeat (per) @(posedge hclk);
            if (line_in !== par_bit(d, nb, p)) ok = 1'b0;
        end
        for (int i = 0; i < ns; i++) begin
            repeat (per) @(posedge hclk);
            if (line_in !== 1'b1) ok = 1'b0;
        end
    endtask
endmodule // ucp_peer_model
`default_nettype wire
